// ### rtl/ircs_pkg.sv
// Purpose: shared constants and types for the register control target port
// Assumes: 20 MHz system clock, one target address block of 10011xx
// Notes: all timing counts derive from the printed times and the clock period
package ircs_pkg;

  // target address: five fixed upper bits, two bits from the strap pin
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam int ADDR_W = 7;

  // strap level codes as sensed on the address-strap pin
  localparam logic [1:0] STRAP_GND_SHORT = 2'h0;
  localparam logic [1:0] STRAP_GND_RES = 2'h1;
  localparam logic [1:0] STRAP_IO_RES = 2'h2;
  localparam logic [1:0] STRAP_IO_SHORT = 2'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int REG_COUNT = 256;

  // bus idle levels of the synchronised pins: scl, sda high
  localparam logic [4:0] PIN_IDLE = 5'h18;

  // host clock generation
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  typedef enum logic [6:0] {
    T_IDLE = 7'h01,
    T_ADDR = 7'h02,
    T_RX = 7'h04,
    T_ACK_WAIT = 7'h08,
    T_ACK_HOLD = 7'h10,
    T_TX = 7'h20,
    T_RACK = 7'h40
  } ircs_tgt_state_type;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BIT = 4'h4,
    H_STOP = 4'h8
  } ircs_host_state_type;

  typedef enum logic [4:0] {
    K_ADDR_WR = 5'h01,
    K_PTR = 5'h02,
    K_WDATA = 5'h04,
    K_ADDR_RD = 5'h08,
    K_RDATA = 5'h10
  } ircs_kind_type;

endpackage

// ### rtl/ircs_link_if.sv
// Purpose: two-wire link between host and target, wired-AND resolution
// Assumes: pull-ups on both wires, every driver is open drain
// Notes: the target never drives scl
`timescale 1ns/100ps
interface ircs_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // a released wire floats to the pulled-up high level
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe,
    input scl,
    input sda
  );

  modport target (
    output dev_sda_o,
    output dev_sda_oe,
    input scl,
    input sda
  );
endinterface

// ### rtl/ircs_sync.sv
// Purpose: two-flop synchroniser for levels entering a clock domain
// Assumes: each bit is an independent level or a slow toggle
// Notes: only the second flop is visible outside
`timescale 1ns/100ps
module ircs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule

// ### rtl/ircs_target.sv
// Purpose: register control target port on the two-wire link
// Assumes: link clock oversamples scl by at least 8x
// Notes: register space lives in the link domain, writes are echoed to CLK_I
// What this block does
// - respond to address 10011 plus strap bits
// - strap levels map to 0x4C through 0x4F
// - eight-bit bytes, MSB first, ninth-bit acknowledge
// - start and stop are sda edges, scl high
// - host opens with start, address, closes stop
// - hold sda low through acknowledge high period
// - no limit on bytes per transaction
// - every register reachable single or multi byte
// - host sends direction zero for writes, pointers
// - first write byte is pointer, then auto-increment
// - acknowledge address, pointer and every data byte
// - read: pointer write, repeated start, read address
// - keep returning successive bytes while host acknowledges
// - host ends read with not-acknowledge then stop
// - drive sda only by open-drain pull-down
// - shutdown leaves both pins unloaded and undriven
`timescale 1ns/100ps
module ircs_target import ircs_pkg::*; (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic LINK_CLK_I,
  input wire logic SHUTDOWN_I,
  input wire logic [1:0] ADDR_STRAP_I,
  output logic REG_WR_STB_O,
  output logic [7:0] REG_WR_ADDR_O,
  output logic [7:0] REG_WR_DATA_O,
  output logic BUSY_O,
  ircs_link_if.target LINK
);
  // ---------------- link domain ----------------
  logic link_rst;
  logic [4:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic shdn_s;
  logic [1:0] strap_s;

  ircs_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk_i(LINK_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(1'b0),
    .q_o(link_rst)
  );

  ircs_sync #(.WIDTH(5), .RST_VAL(PIN_IDLE)) u_pin_sync (
    .clk_i(LINK_CLK_I),
    .rst_i(link_rst),
    .d_i({LINK.scl, LINK.sda, SHUTDOWN_I, ADDR_STRAP_I}),
    .q_o(pin_s)
  );

  assign scl_s = pin_s[4];
  assign sda_s = pin_s[3];
  assign shdn_s = pin_s[2];
  assign strap_s = pin_s[1:0];

  ircs_tgt_state_type state_ff;
  ircs_tgt_state_type nxt_state;
  logic scl_d_ff;
  logic sda_d_ff;
  logic [2:0] bit_cnt_ff;
  logic [2:0] nxt_bit_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic ptr_phase_ff;
  logic nxt_ptr_phase;
  logic rd_mode_ff;
  logic nxt_rd_mode;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic sda_o_ff;
  logic [1:0] strap_cnt_ff;
  logic [1:0] strap_ff;
  logic mem_we;
  logic wr_tgl_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic busy_ff;
  logic [7:0] mem [REG_COUNT];

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic last_bit;
  logic [7:0] byte_in;
  logic [ADDR_W-1:0] my_addr;
  logic addr_hit;
  logic [7:0] rd_byte;

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign last_bit = (bit_cnt_ff == LAST_BIT);
  assign byte_in = {shift_ff[6:0], sda_s};
  assign my_addr = {ADDR_FIXED, strap_ff};
  assign addr_hit = (byte_in[7:1] == my_addr);
  assign rd_byte = mem[ptr_ff];

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_ptr_phase = ptr_phase_ff;
    nxt_rd_mode = rd_mode_ff;
    nxt_sda_oe = sda_oe_ff;
    mem_we = 1'b0;
    if (shdn_s) begin
      // shutdown releases sda and drops any transfer in flight
      nxt_state = T_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      nxt_state = T_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (start_det) begin
      // also a repeated start: pointer is kept for the read that follows
      nxt_state = T_ADDR;
      nxt_bit_cnt = 3'h0;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        T_ADDR: begin
          if (scl_rise) begin
            nxt_shift = byte_in;
            nxt_bit_cnt = 3'(bit_cnt_ff + 3'h1);
            if (last_bit && addr_hit) begin
              nxt_state = T_ACK_WAIT;
              nxt_rd_mode = (byte_in[0] == RW_READ);
              nxt_ptr_phase = (byte_in[0] == RW_WRITE);
            end else if (last_bit) begin
              nxt_state = T_IDLE;
            end
          end
        end
        T_RX: begin
          if (scl_rise) begin
            nxt_shift = byte_in;
            nxt_bit_cnt = 3'(bit_cnt_ff + 3'h1);
            if (last_bit) begin
              nxt_state = T_ACK_WAIT;
              if (ptr_phase_ff) begin
                nxt_ptr = byte_in;
                nxt_ptr_phase = 1'b0;
              end else begin
                mem_we = 1'b1;
                nxt_ptr = 8'(ptr_ff + 8'h01);
              end
            end
          end
        end
        T_ACK_WAIT: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b1;
            nxt_state = T_ACK_HOLD;
          end
        end
        T_ACK_HOLD: begin
          // also entered after a host acknowledge on a read
          if (scl_fall) begin
            nxt_bit_cnt = 3'h0;
            if (rd_mode_ff) begin
              nxt_shift = rd_byte;
              nxt_ptr = 8'(ptr_ff + 8'h01);
              nxt_sda_oe = ~rd_byte[7];
              nxt_state = T_TX;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_state = T_RX;
            end
          end
        end
        T_TX: begin
          if (scl_fall) begin
            if (last_bit) begin
              nxt_sda_oe = 1'b0;
              nxt_state = T_RACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
              nxt_bit_cnt = 3'(bit_cnt_ff + 3'h1);
            end
          end
        end
        T_RACK: begin
          if (scl_rise) begin
            // not-acknowledge ends the read; wait for the stop
            nxt_state = sda_s ? T_IDLE : T_ACK_HOLD;
          end
        end
        T_IDLE: begin
          nxt_state = T_IDLE;
        end
        default: begin
          nxt_state = T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
    if (link_rst) begin
      state_ff <= T_IDLE;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      ptr_phase_ff <= 1'b0;
      rd_mode_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_o_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      ptr_phase_ff <= nxt_ptr_phase;
      rd_mode_ff <= nxt_rd_mode;
      sda_oe_ff <= nxt_sda_oe;
      sda_o_ff <= 1'b0;
      busy_ff <= (nxt_state != T_IDLE);
    end
  end

  // strap is resampled for three link clocks, so the value kept is the one taken after the pin synchroniser has filled
  always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
    if (link_rst) begin
      strap_cnt_ff <= 2'h0;
      strap_ff <= STRAP_GND_SHORT;
    end else if (strap_cnt_ff != STRAP_SETTLE) begin
      strap_cnt_ff <= 2'(strap_cnt_ff + 2'h1);
      strap_ff <= strap_s;
    end
  end

  // register array and write echo; echo words stay stable for a whole byte
  always_ff @(posedge LINK_CLK_I) begin
    if (mem_we) begin
      mem[ptr_ff] <= byte_in;
    end
  end

  always_ff @(posedge LINK_CLK_I or posedge link_rst) begin
    if (link_rst) begin
      wr_tgl_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else if (mem_we) begin
      wr_tgl_ff <= ~wr_tgl_ff;
      wr_addr_ff <= ptr_ff;
      wr_data_ff <= byte_in;
    end
  end

  assign LINK.dev_sda_oe = sda_oe_ff;
  assign LINK.dev_sda_o = sda_o_ff;

  // ---------------- system domain ----------------
  logic [1:0] evt_s;
  logic tgl_d_ff;
  logic wr_evt;

  ircs_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_evt_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .d_i({wr_tgl_ff, busy_ff}),
    .q_o(evt_s)
  );

  assign wr_evt = evt_s[1] ^ tgl_d_ff;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tgl_d_ff <= 1'b0;
      REG_WR_STB_O <= 1'b0;
      REG_WR_ADDR_O <= 8'h00;
      REG_WR_DATA_O <= 8'h00;
      BUSY_O <= 1'b0;
    end else begin
      tgl_d_ff <= evt_s[1];
      REG_WR_STB_O <= wr_evt;
      BUSY_O <= evt_s[0];
      if (wr_evt) begin
        REG_WR_ADDR_O <= wr_addr_ff;
        REG_WR_DATA_O <= wr_data_ff;
      end
    end
  end
endmodule

// ### rtl/ircs_host.sv
// Purpose: host end: runs one pointer write or combined read per command
// Assumes: no clock stretching by the target
// Notes: scl is made from CLK_I by a quarter-period divider
`timescale 1ns/100ps
module ircs_host import ircs_pkg::*; #(
  parameter int QTR_CYCLES = QTR_CYC
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_READ_I,
  input wire logic [6:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_PTR_I,
  input wire logic [7:0] CMD_LEN_I,
  input wire logic [7:0] WR_DATA_I,
  output logic CMD_READY_O,
  output logic WR_TAKE_O,
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic NACK_O,
  output logic DONE_O,
  ircs_link_if.host LINK
);
  logic sda_s;

  ircs_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sda_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(LINK.sda),
    .q_o(sda_s)
  );

  ircs_host_state_type state_ff;
  ircs_kind_type kind_ff;
  logic [15:0] qcnt_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic ack_ff;
  logic rd_ff;
  logic [6:0] addr_ff;
  logic [7:0] ptr_ff;
  logic [7:0] len_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic tick;
  logic accept;
  logic ack_slot;
  logic rx_kind;
  logic byte_end;

  assign tick = (qcnt_ff == 16'(QTR_CYCLES - 1));
  assign accept = CMD_VALID_I & (state_ff == H_IDLE);
  assign ack_slot = (bit_cnt_ff == ACK_SLOT);
  assign rx_kind = (kind_ff == K_RDATA);
  assign byte_end = tick & (state_ff == H_BIT) & (q_ff == 2'h3) & ack_slot;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      qcnt_ff <= 16'h0000;
      q_ff <= 2'h0;
    end else if (state_ff == H_IDLE || tick) begin
      qcnt_ff <= 16'h0000;
      q_ff <= (state_ff == H_IDLE) ? 2'h0 : 2'(q_ff + 2'h1);
    end else begin
      qcnt_ff <= 16'(qcnt_ff + 16'h0001);
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_ff <= H_IDLE;
      kind_ff <= K_ADDR_WR;
      bit_cnt_ff <= 4'h0;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      ack_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 7'h00;
      ptr_ff <= 8'h00;
      len_ff <= 8'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      CMD_READY_O <= 1'b0;
      WR_TAKE_O <= 1'b0;
      RD_DATA_O <= 8'h00;
      RD_VALID_O <= 1'b0;
      NACK_O <= 1'b0;
      DONE_O <= 1'b0;
    end else begin
      WR_TAKE_O <= 1'b0;
      RD_VALID_O <= 1'b0;
      NACK_O <= 1'b0;
      DONE_O <= 1'b0;
      CMD_READY_O <= (state_ff == H_IDLE) & ~accept;
      if (accept) begin
        // every command opens with the write address and the pointer
        state_ff <= H_START;
        kind_ff <= K_ADDR_WR;
        rd_ff <= CMD_READ_I;
        addr_ff <= CMD_ADDR_I;
        ptr_ff <= CMD_PTR_I;
        tx_ff <= {CMD_ADDR_I, RW_WRITE};
        len_ff <= (CMD_READ_I && CMD_LEN_I == 8'h00) ? 8'h01 : CMD_LEN_I;
      end else if (tick) begin
        case (state_ff)
          H_START: begin
            case (q_ff)
              2'h0: begin scl_oe_ff <= 1'b1; sda_oe_ff <= 1'b0; end
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b1;
              default: begin scl_oe_ff <= 1'b1; state_ff <= H_BIT; bit_cnt_ff <= 4'h0; end
            endcase
          end
          H_BIT: begin
            case (q_ff)
              2'h0: begin
                // data moves only while scl is low
                if (ack_slot) sda_oe_ff <= rx_kind & (len_ff != 8'h01);
                else sda_oe_ff <= ~rx_kind & ~tx_ff[7];
              end
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: begin
                if (ack_slot) ack_ff <= ~sda_s;
                else rx_ff <= {rx_ff[6:0], sda_s};
              end
              default: begin
                scl_oe_ff <= 1'b1;
                bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
                if (!ack_slot) tx_ff <= {tx_ff[6:0], 1'b0};
              end
            endcase
          end
          H_STOP: begin
            case (q_ff)
              2'h0: begin scl_oe_ff <= 1'b1; sda_oe_ff <= 1'b1; end
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b0;
              default: begin state_ff <= H_IDLE; DONE_O <= 1'b1; end
            endcase
          end
          default: state_ff <= H_IDLE;
        endcase
        if (byte_end) begin
          bit_cnt_ff <= 4'h0;
          case (kind_ff)
            K_ADDR_WR, K_ADDR_RD: begin
              if (!ack_ff) begin
                NACK_O <= 1'b1;
                state_ff <= H_STOP;
              end else if (kind_ff == K_ADDR_WR) begin
                kind_ff <= K_PTR;
                tx_ff <= ptr_ff;
              end else begin
                kind_ff <= K_RDATA;
              end
            end
            K_PTR, K_WDATA: begin
              if (!ack_ff) begin
                NACK_O <= 1'b1;
                state_ff <= H_STOP;
              end else if (rd_ff) begin
                state_ff <= H_START;
                kind_ff <= K_ADDR_RD;
                tx_ff <= {addr_ff, RW_READ};
              end else if (len_ff == 8'h00) begin
                state_ff <= H_STOP;
              end else begin
                kind_ff <= K_WDATA;
                tx_ff <= WR_DATA_I;
                WR_TAKE_O <= 1'b1;
                len_ff <= 8'(len_ff - 8'h01);
              end
            end
            default: begin
              RD_DATA_O <= rx_ff;
              RD_VALID_O <= 1'b1;
              len_ff <= 8'(len_ff - 8'h01);
              if (len_ff == 8'h01) state_ff <= H_STOP;
            end
          endcase
        end
      end
    end
  end

  assign LINK.host_scl_oe = scl_oe_ff;
  assign LINK.host_sda_oe = sda_oe_ff;
  assign LINK.host_scl_o = 1'b0;
  assign LINK.host_sda_o = 1'b0;
endmodule

// ### bench/ircs_link_properties.sv
// Purpose: wire-level checks on the two-wire link between host and target
// Assumes: CLK_I oversamples the link, scl quarter period well above 8 cycles
// Notes: shutdown only ever changes while the link is idle
`timescale 1ns/100ps
module ircs_link_properties (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic LINK_CLK_I,
  input wire logic SHUTDOWN_I,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  dev_pulldown_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I) dev_sda_oe |-> !dev_sda_o)
    else $error("target drives sda other than low");
  host_pulldown_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (host_sda_oe || host_scl_oe) |-> !(host_sda_o || host_scl_o))
    else $error("host drives a wire other than low");
  dev_change_low_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I) $changed(dev_sda_oe) |-> !scl)
    else $error("target changed sda while scl high");
  ack_hold_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I) $rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("target let go of sda during scl high");
  start_by_host_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I) $fell(sda) && scl |-> host_sda_oe && !dev_sda_oe)
    else $error("start not made by the host");
  start_quiet_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I) $fell(sda) && scl |=> !dev_sda_oe [*8])
    else $error("target drives sda right after a start");
  stop_release_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I) $rose(sda) && scl |=> !dev_sda_oe [*8])
    else $error("target drives sda after a stop");
  shutdown_quiet_a: assert property (
    @(posedge LINK_CLK_I) disable iff (SYS_RST_I) SHUTDOWN_I [*5] |-> !dev_sda_oe)
    else $error("target drives sda in shutdown");
endmodule

// ### bench/testbench.sv
// Purpose: host and target joined on one link, checked against a byte model
// Assumes: scl quarter of 10 cycles so the 125 ns link clock keeps up
// Notes: unwritten registers read unknown, so only written places are read
`timescale 1ns/100ps
module testbench;
  import ircs_pkg::*;
  localparam int QTR = 10;
  localparam int LIMIT = 40000;
  localparam logic [6:0] ADR_TAB [4] = '{7'h4C, 7'h4D, 7'h4E, 7'h4F};
  logic clk, link_clk, sys_rst, shutdown, cmd_valid, cmd_read;
  logic [1:0] strap;
  logic [6:0] cmd_addr, own;
  logic [7:0] cmd_ptr, cmd_len, wr_data, rd_data, wr_addr_o, wr_data_o, rnd, wptr, rptr, rp;
  logic ready, wr_take, rd_valid, nack, done, wr_stb, busy;
  logic [7:0] model_q [256];
  logic [15:0] exp_q [$];
  logic [15:0] e;
  int failures, n_compared, n_rd, cycles;

  ircs_link_if link ();
  ircs_host #(.QTR_CYCLES(QTR)) i_ircs_host (.CLK_I(clk), .SYS_RST_I(sys_rst),
    .CMD_VALID_I(cmd_valid), .CMD_READ_I(cmd_read), .CMD_ADDR_I(cmd_addr),
    .CMD_PTR_I(cmd_ptr), .CMD_LEN_I(cmd_len), .WR_DATA_I(wr_data), .CMD_READY_O(ready),
    .WR_TAKE_O(wr_take), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .NACK_O(nack),
    .DONE_O(done), .LINK(link));
  ircs_target i_ircs_target (.CLK_I(clk), .SYS_RST_I(sys_rst), .LINK_CLK_I(link_clk),
    .SHUTDOWN_I(shutdown), .ADDR_STRAP_I(strap), .REG_WR_STB_O(wr_stb),
    .REG_WR_ADDR_O(wr_addr_o), .REG_WR_DATA_O(wr_data_o), .BUSY_O(busy), .LINK(link));
  ircs_link_properties i_ircs_link_properties (.CLK_I(clk), .SYS_RST_I(sys_rst),
    .LINK_CLK_I(link_clk), .SHUTDOWN_I(shutdown), .host_scl_o(link.host_scl_o),
    .host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

  always #25 clk = ~clk;

  // odd start offset keeps the link clock out of step with the system clock
  initial begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    #2 sys_rst = 1'b1;
    exp_q.delete();
    repeat (12) @(posedge clk);
    #2 sys_rst = 1'b0;
    // strap is taken just after release, traffic waits over 1 us
    repeat (40) @(posedge clk);
  endtask

  task automatic run_cmd(input logic rd, input logic [6:0] adr, input logic [7:0] ptr,
                         input logic [7:0] len, input logic exp_nack);
    logic got;
    logic saw_busy;
    got = 1'b0;
    saw_busy = 1'b0;
    n_rd = 0;
    wptr = ptr;
    rptr = ptr;
    @(posedge clk);
    #2;
    // command is taken at the edge that sees valid with ready already high
    while (ready !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    cmd_read = rd;
    cmd_addr = adr;
    cmd_ptr = ptr;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge clk);
    #2 cmd_valid = 1'b0;
    for (int n = 0; n < 30000 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      if (nack === 1'b1) got = 1'b1;
      if (busy === 1'b1) saw_busy = 1'b1;
    end
    repeat (10) @(posedge clk);
    check("nack", 8'(got), 8'(exp_nack));
    check("busy_seen", 8'(saw_busy), 8'(!shutdown));
    check("busy_end", 8'(busy), 8'h00);
    check("writes_left", 8'(exp_q.size()), 8'h00);
    if (rd) check("read_count", 8'(n_rd), len);
  endtask

  // byte model: pointer written, then each data byte to ptr, ptr+1 with 8-bit wrap
  always @(posedge clk) begin
    // outputs are read once settled, never in the launching time step
    #1;
    if (rd_valid === 1'b1) begin
      check("rd_data", rd_data, model_q[rptr]);
      rptr = rptr + 8'h01;
      n_rd++;
    end
    if (wr_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("extra_write", 8'h01, 8'h00);
      end else begin
        e = exp_q.pop_front();
        check("wr_addr", wr_addr_o, e[15:8]);
        check("wr_data", wr_data_o, e[7:0]);
      end
    end
    if (wr_take === 1'b1) begin
      model_q[wptr] = wr_data;
      exp_q.push_back({wptr, wr_data});
      wptr = wptr + 8'h01;
      rnd = lfsr(rnd);
      #1 wr_data = rnd;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    shutdown = 1'b0;
    strap = 2'h0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_ptr = 8'h00;
    cmd_len = 8'h00;
    rnd = 8'h24;
    wr_data = rnd;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    // each strap level answers to its own address and not to the next one
    for (int s = 0; s < 4; s++) begin
      strap = 2'(s);
      do_reset();
      run_cmd(1'b0, ADR_TAB[s], 8'h00, 8'h00, 1'b0);
      run_cmd(1'b0, ADR_TAB[(s + 1) % 4], 8'h00, 8'h00, 1'b1);
    end
    own = ADR_TAB[3];
    run_cmd(1'b0, own, 8'hFE, 8'h04, 1'b0);
    run_cmd(1'b1, own, 8'hFE, 8'h04, 1'b0);
    rnd = lfsr(rnd);
    rp = rnd;
    run_cmd(1'b0, own, rp, 8'h01, 1'b0);
    run_cmd(1'b1, own, rp, 8'h01, 1'b0);
    run_cmd(1'b1, own, 8'hFF, 8'h02, 1'b0);
    #2 shutdown = 1'b1;
    repeat (10) @(posedge clk);
    run_cmd(1'b0, own, 8'h00, 8'h00, 1'b1);
    #2 shutdown = 1'b0;
    repeat (10) @(posedge clk);
    run_cmd(1'b1, own, 8'h00, 8'h01, 1'b0);
    complete_run();
  end
endmodule
